/* cidr_pkg.sv */
// Constants for the configuration index/data register bank
package cidr_pkg;
    localparam int          NSLOT          = 32;
    localparam int          DW             = 8;
    localparam int          AW             = 16;
    localparam logic [7:0]  IDX_CTRL       = 8'h02;
    localparam logic [7:0]  IDX_PLACE      = 8'h03;
    localparam logic [7:0]  IDX_LDN        = 8'h07;
    localparam logic [7:0]  GLOBAL_LAST    = 8'h2f;
    localparam logic [7:0]  IDX_WATCHDOG_CONTROL   = 8'hf4;
    localparam logic [7:0]  PLACE_RST      = 8'h03;
    localparam logic [7:0]  PLACE_MASK     = 8'h83;
    localparam logic [7:0]  LDN_RST        = 8'h00;
    localparam logic [7:0]  LDN_SOFT       = 8'h00;
    localparam logic [7:0]  AUX_LDN        = 8'h08;
    localparam logic [7:0]  WATCHDOG_CONTROL_RST   = 8'h00;
    localparam logic [7:0]  WATCHDOG_CONTROL_MASK  = 8'hfc;
    localparam int          RUN_EN_BIT     = 7;
    localparam int          SOFT_RST_BIT   = 0;
    localparam int          WDT_STAT_BIT   = 0;
    localparam int          WDT_FORCE_BIT  = 1;
    localparam logic [1:0]  PLACE_E0       = 2'b00;
    localparam logic [1:0]  PLACE_E2       = 2'b01;
    localparam logic [15:0] RUN_PORT_E0    = 16'h00e0;
    localparam logic [15:0] RUN_PORT_E2    = 16'h00e2;
    localparam logic [15:0] RUN_PORT_EA    = 16'h00ea;
    localparam logic [15:0] CFG_PORT_DFLT  = 16'h03f0;
    localparam int          SLOT_BASE1_HI  = 1;
    localparam int          SLOT_BASE1_LO  = 2;
    localparam int          SLOT_BASE2_HI  = 3;
    localparam int          SLOT_BASE2_LO  = 4;
    // Per-device slots: index, reset value, reset classes, run access
    localparam logic [7:0] SLOT_IDX [NSLOT] = '{
        8'h30, 8'h60, 8'h61, 8'h62, 8'h63,
        8'hb0, 8'hb4, 8'hb5, 8'hb6, 8'hb7,
        8'he2, 8'he3, 8'he4, 8'he5, 8'he6, 8'he7,
        8'he8, 8'he9, 8'hea, 8'heb, 8'hec, 8'hed,
        8'hef, 8'hf0, 8'hf1, 8'hf2, 8'hf3,
        8'hf6, 8'hf7, 8'hf8, 8'hfa, 8'hfb};
    localparam logic [7:0] SLOT_RST [NSLOT] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [NSLOT-1:0] SLOT_HARD = 32'hff00_001f;
    localparam logic [NSLOT-1:0] SLOT_SOFT = 32'h0000_001f;
    localparam logic [NSLOT-1:0] SLOT_RUN  = 32'hf800_03e0;
endpackage : cidr_pkg

/* cidr_bank.sv */
// Configuration index/data register bank on the host I/O pins
`timescale 1ns/1ps
`default_nettype none
module cidr_bank #(
    parameter logic [15:0] CFG_PORT = cidr_pkg::CFG_PORT_DFLT
) (
    // Clock and power-on reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // Host I/O pins
    input  wire logic [15:0]           io_addr_i,
    input  wire logic                  io_wr_i,
    input  wire logic                  io_rd_i,
    input  wire logic [7:0]            io_data_i,
    output logic      [7:0]            io_data_o,
    output logic                       io_data_oe_o,
    input  wire logic                  hard_rst_i,
    // Mode and watchdog status
    input  wire logic                  cfg_mode_i,
    input  wire logic                  wdt_status_i,
    // Register contents
    output logic [cidr_pkg::NSLOT*8-1:0] dev_regs_o,
    output logic [15:0]                base1_o,
    output logic [15:0]                base2_o,
    output logic [7:0]                 ldn_o,
    output logic [7:0]                 place_o,
    output logic [7:0]                 watchdog_control_o,
    output logic                       wdt_force_o,
    output logic                       soft_rst_o
);
    localparam int NS = cidr_pkg::NSLOT;

    logic [15:0] addr_s1_r;
    logic [15:0] addr_s2_r;
    logic [7:0]  data_s1_r;
    logic [7:0]  data_s2_r;
    logic [3:0]  ctl_s1_r;
    logic [3:0]  ctl_s2_r;
    logic        wr_q_r;
    logic        wr_edge;
    logic        rd_s2;
    logic        hard_s2;
    logic        stat_s2;
    logic [7:0]  cfg_index_r;
    logic [7:0]  run_index_r;
    logic [7:0]  regs_r [NS];
    logic [15:0] run_port;
    logic        hit_cfg_idx;
    logic        hit_cfg_dat;
    logic        hit_run_idx;
    logic        hit_run_dat;
    logic        acc_cfg;
    logic        acc_run;
    logic [7:0]  acc_idx;
    logic        slot_hit;
    logic [4:0]  slot_num;
    logic        dev_ok;
    logic        glob_ok;
    logic        wdt_ok;
    logic [NS-1:0] slot_wr;
    logic [7:0]  rd_val;

    // Two-stage synchronisers for the host pins
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_s1_r <= 16'h0000;
            addr_s2_r <= 16'h0000;
            data_s1_r <= 8'h00;
            data_s2_r <= 8'h00;
            ctl_s1_r  <= 4'h0;
            ctl_s2_r  <= 4'h0;
            wr_q_r    <= 1'b0;
        end
        else
        begin
            addr_s1_r <= io_addr_i;
            addr_s2_r <= addr_s1_r;
            data_s1_r <= io_data_i;
            data_s2_r <= data_s1_r;
            ctl_s1_r  <= {wdt_status_i, hard_rst_i, io_rd_i, io_wr_i};
            ctl_s2_r  <= ctl_s1_r;
            wr_q_r    <= ctl_s2_r[0];
        end
    end

    assign wr_edge = ctl_s2_r[0] & ~wr_q_r;
    assign rd_s2   = ctl_s2_r[1];
    assign hard_s2 = ctl_s2_r[2];
    assign stat_s2 = ctl_s2_r[3];

    // Run-mode index port placement
    always_comb
    begin
        unique case (place_o[1:0])
            cidr_pkg::PLACE_E0: run_port = cidr_pkg::RUN_PORT_E0;
            cidr_pkg::PLACE_E2: run_port = cidr_pkg::RUN_PORT_E2;
            default:            run_port = cidr_pkg::RUN_PORT_EA;
        endcase
    end

    // Port decode over the full address
    always_comb
    begin
        hit_cfg_idx = cfg_mode_i && (addr_s2_r == CFG_PORT);
        hit_cfg_dat = cfg_mode_i && (addr_s2_r == CFG_PORT + 16'h0001);
        hit_run_idx = !cfg_mode_i && (addr_s2_r == run_port);
        hit_run_dat = !cfg_mode_i && (addr_s2_r == run_port + 16'h0001);
        acc_cfg     = hit_cfg_dat;
        acc_run     = hit_run_dat && place_o[cidr_pkg::RUN_EN_BIT];
        acc_idx     = acc_cfg ? cfg_index_r : run_index_r;
    end

    // Slot lookup compares all eight index bits
    always_comb
    begin
        slot_hit = 1'b0;
        slot_num = 5'd0;
        for (int k = 0; k < NS; k++)
        begin
            if (acc_idx == cidr_pkg::SLOT_IDX[k])
            begin
                slot_hit = 1'b1;
                slot_num = 5'(k);
            end
        end
    end

    // Access qualification per register class
    always_comb
    begin
        glob_ok = acc_cfg && (acc_idx <= cidr_pkg::GLOBAL_LAST);
        dev_ok  = slot_hit
                && ((acc_cfg && ldn_o == cidr_pkg::AUX_LDN)
                || (acc_run && cidr_pkg::SLOT_RUN[slot_num]));
        wdt_ok  = (acc_idx == cidr_pkg::IDX_WATCHDOG_CONTROL)
                && ((acc_cfg && ldn_o == cidr_pkg::AUX_LDN) || acc_run);
    end

    // Read data mux; everything else reads zero
    always_comb
    begin
        rd_val = 8'h00;
        if (hit_cfg_idx)
            rd_val = cfg_index_r;
        else if (hit_run_idx)
            rd_val = run_index_r;
        else if (glob_ok && acc_idx == cidr_pkg::IDX_PLACE)
            rd_val = place_o;
        else if (glob_ok && acc_idx == cidr_pkg::IDX_LDN)
            rd_val = ldn_o;
        else if (dev_ok)
            rd_val = regs_r[slot_num];
        else if (wdt_ok)
        begin
            rd_val = watchdog_control_o & cidr_pkg::WATCHDOG_CONTROL_MASK;
            rd_val[cidr_pkg::WDT_STAT_BIT] = stat_s2;
        end
    end

    // Read drive of the data pins
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            io_data_o    <= 8'h00;
            io_data_oe_o <= 1'b0;
        end
        else
        begin
            io_data_o    <= rd_val;
            io_data_oe_o <= rd_s2
                && (hit_cfg_idx || hit_cfg_dat || hit_run_idx || acc_run);
        end
    end

    // Index registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_index_r <= 8'h00;
            run_index_r <= 8'h00;
        end
        else if (wr_edge && hit_cfg_idx)
            cfg_index_r <= data_s2_r;
        else if (wr_edge && hit_run_idx)
            run_index_r <= data_s2_r;
    end

    // Soft reset pulse from the configuration control register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            soft_rst_o <= 1'b0;
        else
            soft_rst_o <= wr_edge && glob_ok && acc_idx == cidr_pkg::IDX_CTRL
                && data_s2_r[cidr_pkg::SOFT_RST_BIT];
    end

    // Placement register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            place_o <= cidr_pkg::PLACE_RST;
        else if (hard_s2)
            place_o <= cidr_pkg::PLACE_RST;
        else if (wr_edge && glob_ok && acc_idx == cidr_pkg::IDX_PLACE)
            place_o <= data_s2_r & cidr_pkg::PLACE_MASK;
    end

    // Logical device number
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ldn_o <= cidr_pkg::LDN_RST;
        else if (hard_s2)
            ldn_o <= cidr_pkg::LDN_RST;
        else if (wr_edge && glob_ok && acc_idx == cidr_pkg::IDX_CTRL
                 && data_s2_r[cidr_pkg::SOFT_RST_BIT])
            ldn_o <= cidr_pkg::LDN_SOFT;
        else if (wr_edge && glob_ok && acc_idx == cidr_pkg::IDX_LDN)
            ldn_o <= data_s2_r;
    end

    // Watchdog control: stored bits plus force pulse
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            watchdog_control_o  <= cidr_pkg::WATCHDOG_CONTROL_RST;
            wdt_force_o <= 1'b0;
        end
        else
        begin
            wdt_force_o <= wr_edge && wdt_ok
                && data_s2_r[cidr_pkg::WDT_FORCE_BIT];
            if (wr_edge && wdt_ok)
                watchdog_control_o <= data_s2_r & cidr_pkg::WATCHDOG_CONTROL_MASK;
        end
    end

    // Per-device register slots
    for (genvar g = 0; g < NS; g++)
    begin : g_slot
        assign slot_wr[g] = wr_edge && dev_ok && (slot_num == 5'(g));
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
                regs_r[g] <= cidr_pkg::SLOT_RST[g];
            else if (hard_s2 && cidr_pkg::SLOT_HARD[g])
                regs_r[g] <= cidr_pkg::SLOT_RST[g];
            else if (soft_rst_o && cidr_pkg::SLOT_SOFT[g])
                regs_r[g] <= cidr_pkg::SLOT_RST[g];
            else if (slot_wr[g])
                regs_r[g] <= data_s2_r;
        end
        assign dev_regs_o[g*8 +: 8] = regs_r[g];
    end

    // Base address pairs, high byte at the lower index
    assign base1_o = {regs_r[cidr_pkg::SLOT_BASE1_HI],
                      regs_r[cidr_pkg::SLOT_BASE1_LO]};
    assign base2_o = {regs_r[cidr_pkg::SLOT_BASE2_HI],
                      regs_r[cidr_pkg::SLOT_BASE2_LO]};

    // Checks
    soft_pulse_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        soft_rst_o |=> !soft_rst_o)
        else $error("soft reset bit did not clear");

    soft_load_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        soft_rst_o && !hard_s2 |=> regs_r[0] == cidr_pkg::SLOT_RST[0]
        && ldn_o == cidr_pkg::LDN_SOFT)
        else $error("soft reset values not loaded");

    run_block_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_edge && hit_run_dat && !place_o[cidr_pkg::RUN_EN_BIT] && !hard_s2
        |=> $stable(dev_regs_o))
        else $error("run-mode write passed while blocked");

    place_map_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        place_o[1] |-> run_port == cidr_pkg::RUN_PORT_EA)
        else $error("run index port misplaced");

    index_full_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_edge && hit_cfg_idx |=> cfg_index_r == $past(data_s2_r))
        else $error("index port lost bits");

    unmapped_zero_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        acc_cfg && !slot_hit && !wdt_ok && acc_idx > cidr_pkg::IDX_LDN
        |=> io_data_o == 8'h00)
        else $error("unmapped register read nonzero");

    global_gate_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !cfg_mode_i && !hard_s2 |=> $stable(ldn_o))
        else $error("global register changed outside config mode");

    ldn_write_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_edge && glob_ok && acc_idx == cidr_pkg::IDX_LDN && !hard_s2
        |=> ldn_o == $past(data_s2_r))
        else $error("device number not written");

    route_write_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_edge && dev_ok && !hard_s2 && !soft_rst_o
        |=> regs_r[$past(slot_num)] == $past(data_s2_r))
        else $error("data port write not routed");

    wdt_mixed_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wdt_ok |=> !io_data_o[cidr_pkg::WDT_FORCE_BIT])
        else $error("write-only watchdog bit read back");

    global_zone_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        glob_ok && acc_idx != cidr_pkg::IDX_PLACE
        && acc_idx != cidr_pkg::IDX_LDN |=> io_data_o == 8'h00)
        else $error("reserved global index read nonzero");
endmodule : cidr_bank
`default_nettype wire

/* cidr_host.sv */
// Host model issuing I/O write and read cycles to the register bank
`timescale 1ns/1ps
`default_nettype none
module cidr_host (
    // Clock
    input  wire logic        clk_i,
    // Host I/O pins
    output logic      [15:0] io_addr_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [7:0]  io_data_o,
    input  wire logic [7:0]  io_data_i,
    input  wire logic        io_data_oe_i
);
    initial
    begin
        io_addr_o = 16'h0000;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_data_o = 8'h00;
    end
    task automatic edges(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : edges
    // Write: strobe high four clocks, low three
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        edges(1);
        io_addr_o = a;
        io_data_o = d;
        io_wr_o = 1'b1;
        edges(4);
        io_wr_o = 1'b0;
        edges(3);
        io_data_o = ~d;
    endtask : wr
    // Read: strobe high five clocks, sample, low four
    task automatic rd(input logic [15:0] a, output logic [7:0] d,
                      output logic oe);
        edges(1);
        io_addr_o = a;
        io_rd_o = 1'b1;
        edges(5);
        // Undriven data lines read as pulled-up ones
        d = io_data_oe_i ? io_data_i : 8'hff;
        oe = io_data_oe_i;
        io_rd_o = 1'b0;
        edges(4);
    endtask : rd
endmodule : cidr_host
`default_nettype wire

/* cidr_bank_tb.sv */
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cidr_bank_tb;
    localparam logic [15:0] CP = 16'h03f0;
    logic             clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic             hard_rst_i = 1'b0;
    logic             cfg_mode_i = 1'b1;
    logic             wdt_status_i = 1'b0;
    wire logic [15:0] addr;
    wire logic        wr;
    wire logic        rd;
    wire logic [7:0]  din;
    wire logic [7:0]  dout;
    wire logic        oe;
    wire logic [15:0] base1;
    wire logic [15:0] base2;
    wire logic [255:0] dregs;
    wire logic [7:0]  ldn;
    wire logic [7:0]  place;
    wire logic [7:0]  wdt;
    wire logic        force_p;
    wire logic        soft_p;
    int               fails = 0;
    int               samples_checked = 0;
    int               cycles = 0;
    int               n_soft = 0;
    int               n_force = 0;
    logic [7:0]       rsv [8] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06,
                                  8'h08, 8'h1f, 8'h2f};
    logic [15:0]      rp [4] = '{16'h00e0, 16'h00e2, 16'h00ea, 16'h00ea};

    cidr_host host (.clk_i(clk_i), .io_addr_o(addr), .io_wr_o(wr),
        .io_rd_o(rd), .io_data_o(din), .io_data_i(dout),
        .io_data_oe_i(oe));
    cidr_bank #(.CFG_PORT(CP)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd), .io_data_i(din),
        .io_data_o(dout), .io_data_oe_o(oe), .hard_rst_i(hard_rst_i),
        .cfg_mode_i(cfg_mode_i), .wdt_status_i(wdt_status_i),
        .dev_regs_o(dregs), .base1_o(base1), .base2_o(base2), .ldn_o(ldn),
        .place_o(place), .watchdog_control_o(wdt), .wdt_force_o(force_p),
        .soft_rst_o(soft_p));

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (soft_p === 1'b1) n_soft++;
        if (force_p === 1'b1) n_force++;
        if (cycles == 40000)
        begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [15:0] s,
                       input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Index write then data write
    task automatic cw(input logic [7:0] i, input logic [7:0] v);
        host.wr(CP, i);
        host.wr(CP + 16'h0001, v);
    endtask : cw
    task automatic cr(input string nm, input logic [7:0] i,
                      input logic [7:0] e);
        logic [7:0] d;
        logic       o;
        host.wr(CP, i);
        host.rd(CP + 16'h0001, d, o);
        chk(nm, {8'h00, d}, {8'h00, e});
        chk("oe", {15'h0000, o}, 16'h0001);
    endtask : cr
    task automatic rr(input logic [15:0] p, input logic [7:0] e);
        logic [7:0] d;
        logic       o;
        host.rd(p, d, o);
        chk("run rd", {8'h00, d}, {8'h00, e});
    endtask : rr

    task automatic t_reset();
        cr("place", 8'h03, 8'h03);
        cr("ldn", 8'h07, 8'h00);
        cw(8'h07, 8'h08);
        for (int k = 10; k < 32; k++)
            cr("slot", cidr_pkg::SLOT_IDX[k], cidr_pkg::SLOT_RST[k]);
    endtask : t_reset
    task automatic t_rsvd();
        foreach (rsv[k])
        begin
            cw(rsv[k], 8'hff);
            cr("rsvd", rsv[k], 8'h00);
        end
        cw(8'h03, 8'hff);
        cr("place bits", 8'h03, 8'h83);
        cr("alias", 8'h83, 8'h00);
        cr("alias ldn", 8'h87, 8'h00);
        cr("ldn", 8'h07, 8'h08);
        cw(8'h03, 8'h03);
    endtask : t_rsvd
    task automatic t_base();
        cw(8'h61, 8'h34);
        cw(8'h60, 8'h12);
        chk("base1", base1, 16'h1234);
        cw(8'h62, 8'hab);
        cw(8'h63, 8'hcd);
        chk("base2", base2, 16'habcd);
        cr("base hi", 8'h60, 8'h12);
    endtask : t_base
    task automatic t_cfg_only();
        logic [7:0] d;
        logic       o;
        host.wr(CP, 8'h07);
        cfg_mode_i = 1'b0;
        host.rd(CP + 16'h0001, d, o);
        chk("ldn run", {8'h00, d}, 16'h00ff);
        chk("oe run", {15'h0000, o}, 16'h0000);
        host.wr(CP + 16'h0001, 8'h05);
        cfg_mode_i = 1'b1;
        cr("ldn kept", 8'h07, 8'h08);
    endtask : t_cfg_only
    task automatic t_run();
        cfg_mode_i = 1'b0;
        host.wr(16'h00ea, 8'hf6);
        host.wr(16'h00eb, 8'h5a);
        cfg_mode_i = 1'b1;
        cr("blocked", 8'hf6, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            cw(8'h03, {6'b100000, 2'(c)});
            chk("place", {8'h00, place}, {14'h0020, 2'(c)});
            cfg_mode_i = 1'b0;
            host.wr(rp[c], 8'hf6);
            host.wr(rp[c] + 16'h0001, 8'h10 + 8'(c));
            rr(rp[c] + 16'h0001, 8'h10 + 8'(c));
            cfg_mode_i = 1'b1;
            cr("gp1", 8'hf6, 8'h10 + 8'(c));
        end
        cw(8'h03, 8'h03);
    endtask : t_run
    task automatic t_ldn();
        cw(8'h07, 8'h05);
        cr("other dev", 8'hf6, 8'h00);
        cw(8'h07, 8'h08);
        cr("gp1 back", 8'hf6, 8'h13);
    endtask : t_ldn
    task automatic t_wdt();
        wdt_status_i = 1'b1;
        n_force = 0;
        cw(8'hf4, 8'hff);
        chk("force", 16'(n_force), 16'h0001);
        chk("wdt out", {8'h00, wdt}, 16'h00fc);
        cr("wdt rd", 8'hf4, 8'hfd);
        wdt_status_i = 1'b0;
        cr("wdt rd0", 8'hf4, 8'hfc);
    endtask : t_wdt
    task automatic t_soft();
        cw(8'h30, 8'h01);
        cw(8'he2, 8'h05);
        n_soft = 0;
        cw(8'h02, 8'h01);
        chk("soft", 16'(n_soft), 16'h0001);
        chk("ldn soft", {8'h00, ldn}, 16'h0000);
        cr("ctrl", 8'h02, 8'h00);
        cw(8'h07, 8'h08);
        cr("activate", 8'h30, 8'h00);
        cr("base hi", 8'h60, 8'h00);
        cr("pin kept", 8'he2, 8'h05);
        cr("gp1 kept", 8'hf6, 8'h13);
    endtask : t_soft
    task automatic t_hard();
        cw(8'hf2, 8'h5a);
        cw(8'h03, 8'h82);
        hard_rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        hard_rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        chk("hard place", {8'h00, place}, 16'h0003);
        chk("hard ldn", {8'h00, ldn}, 16'h0000);
        chk("hard wdt", {8'h00, wdt}, 16'h00fc);
        cw(8'h07, 8'h08);
        cr("watchdog_timeout_value", 8'hf2, 8'h00);
        cr("pin hard", 8'he2, 8'h05);
        chk("pin out", {8'h00, dregs[87:80]}, 16'h0005);
    endtask : t_hard

    initial
    begin
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_rsvd();
        t_base();
        t_cfg_only();
        t_run();
        t_ldn();
        t_wdt();
        t_soft();
        t_hard();
        finish_test();
    end
endmodule : cidr_bank_tb
`default_nettype wire
